// >>> repeater_channel_config_regs.sv
// repeater_channel_config_regs: channel 4 thresholds, channel 5
// termination, equalizer and output swing settings
// assumes a one-cycle strobe register port and asynchronous pin inputs
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module repeater_channel_config_regs
  import repeater_cfg_pkg::*;
#(
  parameter int DETECT_PERIOD_CYCLES = DETECT_PERIOD_CYC
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // strap pins, asynchronous
  input  wire logic [1:0] assert_thresh_pin_i,
  input  wire logic [1:0] deassert_thresh_pin_i,
  input  wire logic [1:0] presence_mode_pin_i,
  // channel 5 analog detect result, asynchronous
  input  wire logic       channel5_output_found_i,
  // channel 4 signal-detect settings
  output logic      [1:0] assert_thresh_sel_o,
  output logic      [1:0] deassert_thresh_sel_o,
  // channel 5 input termination and detect test
  output logic            channel5_input_terminated_o,
  output logic            channel5_output_test_o,
  // channel 5 equalizer and driver
  output logic      [7:0] channel5_equalizer_level_o,
  output logic            channel5_short_protect_en_o,
  output logic      [2:0] channel5_output_swing_o
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [PIN_SYNC_W-1:0] pin_raw;
  logic [PIN_SYNC_W-1:0] pin_s1;
  logic [PIN_SYNC_W-1:0] pin_s2;
  logic [PIN_SYNC_W-1:0] pin_s3;
  logic [PIN_SYNC_W-1:0] pin_stable;

  assign pin_raw = {channel5_output_found_i,
                    presence_mode_pin_i,
                    deassert_thresh_pin_i,
                    assert_thresh_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_SYNC_W; gi++) begin : g_pin_sync
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_s1[gi] <= 1'b0;
          pin_s2[gi] <= 1'b0;
          pin_s3[gi] <= 1'b0;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
        end
      end

      // a change counts once stages two and three agree
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_stable[gi] <= 1'b0;
        end else if (pin_s2[gi] == pin_s3[gi]) begin
          pin_stable[gi] <= pin_s3[gi];
        end
      end
    end
  endgenerate

  logic [1:0] assert_pin;
  logic [1:0] deassert_pin;
  logic [1:0] mode_pin;
  logic       found_sync;

  assign assert_pin   = pin_stable[1:0];
  assign deassert_pin = pin_stable[3:2];
  assign mode_pin     = pin_stable[5:4];
  assign found_sync   = pin_stable[6];

  ////////////////////////////////////////////////////////////////////////
  // write decode
  logic wr_override;
  logic wr_thresh;
  logic wr_spare_a;
  logic wr_spare_b;
  logic wr_term;
  logic wr_eq;
  logic wr_swing;

  assign wr_override = wr_i && (addr_i == ADDR_OVERRIDE);
  assign wr_thresh   = wr_i && (addr_i == ADDR_CH4_THRESH);
  assign wr_spare_a  = wr_i && (addr_i == ADDR_SPARE_A);
  assign wr_spare_b  = wr_i && (addr_i == ADDR_SPARE_B);
  assign wr_term     = wr_i && (addr_i == ADDR_CH5_TERM);
  assign wr_eq       = wr_i && (addr_i == ADDR_CH5_EQ);
  assign wr_swing    = wr_i && (addr_i == ADDR_CH5_SWING);

  ////////////////////////////////////////////////////////////////////////
  // register storage
  logic       ovr_thresh;
  logic       ovr_term;
  logic [3:0] ch4_detect_thresholds;
  logic [7:0] spare_config_a;
  logic [7:0] spare_config_b;
  logic [1:0] ch5_termination_detect;
  logic [7:0] ch5_equalizer_level;
  logic [7:0] ch5_output_swing;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovr_thresh <= RST_OVERRIDE[OVR_THRESH_BIT];
      ovr_term   <= RST_OVERRIDE[OVR_TERM_BIT];
    end else if (wr_override) begin
      ovr_thresh <= wdata_i[OVR_THRESH_BIT];
      ovr_term   <= wdata_i[OVR_TERM_BIT];
    end
  end

  // reserved bits 7:4 are not stored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch4_detect_thresholds <= RST_THRESH;
    end else if (wr_thresh) begin
      ch4_detect_thresholds <= wdata_i[ASSERT_HI:DEASSERT_LO];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spare_config_a <= RST_SPARE;
      spare_config_b <= RST_SPARE;
    end else begin
      if (wr_spare_a) begin
        spare_config_a <= wdata_i;
      end
      if (wr_spare_b) begin
        spare_config_b <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch5_termination_detect <= RST_TERM;
    end else if (wr_term) begin
      ch5_termination_detect <= wdata_i[TERM_HI:TERM_LO];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch5_equalizer_level <= RST_EQ;
    end else if (wr_eq) begin
      ch5_equalizer_level <= wdata_i;
    end
  end

  // bits 6:3 stored as written, software keeps them at 0101
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch5_output_swing <= RST_SWING;
    end else if (wr_swing) begin
      ch5_output_swing <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // source selection between register and pins
  logic [1:0] eff_assert;
  logic [1:0] eff_deassert;
  logic [1:0] eff_term_mode;

  assign eff_assert    = ovr_thresh ? ch4_detect_thresholds[ASSERT_HI:ASSERT_LO]
                                    : assert_pin;
  assign eff_deassert  = ovr_thresh ? ch4_detect_thresholds[DEASSERT_HI:DEASSERT_LO]
                                    : deassert_pin;
  assign eff_term_mode = ovr_term ? ch5_termination_detect : mode_pin;

  ////////////////////////////////////////////////////////////////////////
  // receiver presence sequencing
  logic        seq_terminated;
  logic        seq_test;
  term_state_t seq_state;
  logic [5:0]  seq_attempts;

  receiver_presence_seq #(
    .DETECT_PERIOD_CYCLES (DETECT_PERIOD_CYCLES)
  ) u_presence_seq (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n_i),
    .mode_i       (eff_term_mode),
    .found_i      (found_sync),
    .test_o       (seq_test),
    .terminated_o (seq_terminated),
    .state_o      (seq_state),
    .attempts_o   (seq_attempts)
  );

  ////////////////////////////////////////////////////////////////////////
  // registered setting outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      assert_thresh_sel_o   <= RST_THRESH[ASSERT_HI:ASSERT_LO];
      deassert_thresh_sel_o <= RST_THRESH[DEASSERT_HI:DEASSERT_LO];
    end else begin
      assert_thresh_sel_o   <= eff_assert;
      deassert_thresh_sel_o <= eff_deassert;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel5_input_terminated_o <= 1'b0;
      channel5_output_test_o      <= 1'b0;
    end else begin
      channel5_input_terminated_o <= seq_terminated;
      channel5_output_test_o      <= seq_test;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel5_equalizer_level_o  <= RST_EQ;
      channel5_short_protect_en_o <= RST_SWING[PROTECT_BIT];
      channel5_output_swing_o     <= RST_SWING[SWING_HI:SWING_LO];
    end else begin
      channel5_equalizer_level_o  <= ch5_equalizer_level;
      channel5_short_protect_en_o <= ch5_output_swing[PROTECT_BIT];
      channel5_output_swing_o     <= ch5_output_swing[SWING_HI:SWING_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path, data one cycle after the strobe
  logic [7:0] rd_override;
  logic [7:0] rd_thresh;
  logic [7:0] rd_term;
  logic [7:0] rd_status;
  logic [7:0] next_rdata;

  always_comb begin
    rd_override                 = READ_ZERO;
    rd_override[OVR_THRESH_BIT] = ovr_thresh;
    rd_override[OVR_TERM_BIT]   = ovr_term;
    rd_thresh                   = READ_ZERO;
    rd_thresh[ASSERT_HI:DEASSERT_LO] = ch4_detect_thresholds;
    rd_term                     = READ_ZERO;
    rd_term[TERM_HI:TERM_LO]    = ch5_termination_detect;
    rd_term[TERM_STATUS_BIT]    = seq_terminated;
    rd_status                   = {seq_state[1:0], seq_attempts};
  end

  always_comb begin
    if (addr_i == ADDR_OVERRIDE) begin
      next_rdata = rd_override;
    end else if (addr_i == ADDR_CH4_THRESH) begin
      next_rdata = rd_thresh;
    end else if (addr_i == ADDR_SPARE_A) begin
      next_rdata = spare_config_a;
    end else if (addr_i == ADDR_SPARE_B) begin
      next_rdata = spare_config_b;
    end else if (addr_i == ADDR_CH5_TERM) begin
      next_rdata = rd_term;
    end else if (addr_i == ADDR_CH5_EQ) begin
      next_rdata = ch5_equalizer_level;
    end else if (addr_i == ADDR_CH5_SWING) begin
      next_rdata = ch5_output_swing;
    end else if (addr_i == ADDR_CH5_STATUS) begin
      next_rdata = rd_status;
    end else begin
      next_rdata = READ_ZERO;
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= READ_ZERO;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= READ_ZERO;
    end
  end

endmodule // repeater_channel_config_regs

// >>> repeater_cfg_pkg.sv
// repeater_cfg_pkg: offsets, field positions, reset values, timing
// assumes a 20 MHz core clock and an 8-bit management register port
package repeater_cfg_pkg;

  // register offsets
  localparam logic [7:0] ADDR_OVERRIDE      = 8'h08;
  localparam logic [7:0] ADDR_CH4_THRESH    = 8'h2F;
  localparam logic [7:0] ADDR_SPARE_A       = 8'h30;
  localparam logic [7:0] ADDR_SPARE_B       = 8'h31;
  localparam logic [7:0] ADDR_CH5_TERM      = 8'h32;
  localparam logic [7:0] ADDR_CH5_EQ        = 8'h33;
  localparam logic [7:0] ADDR_CH5_SWING     = 8'h34;
  localparam logic [7:0] ADDR_CH5_STATUS    = 8'h3F;

  // field positions
  localparam int OVR_THRESH_BIT  = 6;
  localparam int OVR_TERM_BIT    = 3;
  localparam int ASSERT_HI       = 3;
  localparam int ASSERT_LO       = 2;
  localparam int DEASSERT_HI     = 1;
  localparam int DEASSERT_LO     = 0;
  localparam int TERM_HI         = 3;
  localparam int TERM_LO         = 2;
  localparam int TERM_STATUS_BIT = 7;
  localparam int PROTECT_BIT     = 7;
  localparam int SWING_RSV_HI    = 6;
  localparam int SWING_RSV_LO    = 3;
  localparam int SWING_HI        = 2;
  localparam int SWING_LO        = 0;

  // reset values
  localparam logic [7:0] RST_OVERRIDE = 8'h00;
  localparam logic [3:0] RST_THRESH   = 4'h0;
  localparam logic [7:0] RST_SPARE    = 8'h00;
  localparam logic [1:0] RST_TERM     = 2'h0;
  localparam logic [7:0] RST_EQ       = 8'h2F;
  localparam logic [7:0] RST_SWING    = 8'hAD;
  localparam logic [7:0] READ_ZERO    = 8'h00;

  // receiver-detect modes
  localparam logic [1:0] TERM_MODE_HIZ     = 2'h0;
  localparam logic [1:0] TERM_MODE_ONCE    = 2'h1;
  localparam logic [1:0] TERM_MODE_FOREVER = 2'h2;
  localparam logic [1:0] TERM_MODE_FIXED   = 2'h3;

  // timing
  localparam int          CLK_HZ               = 20_000_000;
  localparam int          DETECT_PERIOD_MS     = 12;
  localparam int          DETECT_WINDOW_MS     = 600;
  localparam int          DETECT_PERIOD_CYC    = CLK_HZ / 1000 * DETECT_PERIOD_MS;
  localparam logic [5:0]  DETECT_ATTEMPT_LIMIT = 6'(DETECT_WINDOW_MS / DETECT_PERIOD_MS);
  localparam logic [17:0] DETECT_SETTLE_CYC    = 18'h00008;
  localparam int          TIMER_W              = 18;
  localparam int          PIN_SYNC_W           = 7;

  typedef enum logic [2:0] {
    TS_HIZ     = 3'b000,
    TS_FIXED   = 3'b001,
    TS_TEST    = 3'b010,
    TS_WAIT    = 3'b011,
    TS_FOUND   = 3'b100,
    TS_GAVE_UP = 3'b101
  } term_state_t;

endpackage

// >>> receiver_presence_seq.sv
// receiver_presence_seq: termination state and periodic detect tests
// assumes found_i is already synchronised to clk_i
`timescale 1ns/1ps
module receiver_presence_seq
  import repeater_cfg_pkg::*;
#(
  parameter int DETECT_PERIOD_CYCLES = DETECT_PERIOD_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic [1:0]  mode_i,
  input  wire logic        found_i,
  // results
  output logic             test_o,
  output logic             terminated_o,
  output term_state_t      state_o,
  output logic [5:0]       attempts_o
);

  localparam logic [TIMER_W-1:0] PERIOD_LAST = TIMER_W'(DETECT_PERIOD_CYCLES - 1);

  term_state_t        state;
  term_state_t        next_state;
  logic [1:0]         mode_q;
  logic [TIMER_W-1:0] timer;
  logic [5:0]         attempts;
  logic               restart;
  logic               decide;
  logic               period_end;
  logic               limit_hit;

  assign restart    = (mode_i != mode_q);
  assign decide     = (state == TS_TEST) && (timer == DETECT_SETTLE_CYC - 18'h00001);
  assign period_end = (timer == PERIOD_LAST);
  assign limit_hit  = (mode_q == TERM_MODE_ONCE) && (attempts + 6'h01 == DETECT_ATTEMPT_LIMIT);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    if (restart) begin
      case (mode_i)
        TERM_MODE_HIZ:   next_state = TS_HIZ;
        TERM_MODE_FIXED: next_state = TS_FIXED;
        default:         next_state = TS_TEST;
      endcase
    end else begin
      case (state)
        TS_TEST: begin
          if (decide && found_i) begin
            next_state = TS_FOUND;
          end else if (decide && limit_hit) begin
            next_state = TS_GAVE_UP;
          end else if (decide) begin
            next_state = TS_WAIT;
          end
        end
        TS_WAIT: begin
          if (period_end) begin
            next_state = TS_TEST;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state  <= TS_HIZ;
      mode_q <= TERM_MODE_HIZ;
    end else begin
      state  <= next_state;
      mode_q <= mode_i;
    end
  end

  // one period spans a test plus its wait
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer <= '0;
    end else if (restart || period_end || (next_state != TS_TEST && next_state != TS_WAIT)) begin
      timer <= '0;
    end else begin
      timer <= timer + 18'h00001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      attempts <= '0;
    end else if (restart) begin
      attempts <= '0;
    end else if (decide) begin
      attempts <= attempts + 6'h01;
    end
  end

  assign test_o       = (state == TS_TEST) && (timer == '0) && !restart;
  assign terminated_o = (state == TS_FIXED) || (state == TS_FOUND);
  assign state_o      = state;
  assign attempts_o   = attempts;

endmodule // receiver_presence_seq

// >>> repeater_channel_config_regs_monitor.sv
// repeater_channel_config_regs_monitor: port-level checks of the register block
// assumes binding to the design top, one clock domain
`timescale 1ns/1ps
module repeater_channel_config_regs_monitor
  import repeater_cfg_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  // channel 5 outputs
  input  wire logic       channel5_input_terminated_o,
  input  wire logic       channel5_output_test_o,
  input  wire logic [7:0] channel5_equalizer_level_o,
  input  wire logic       channel5_short_protect_en_o,
  input  wire logic [2:0] channel5_output_swing_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // write data fields, so that their history can be taken
  logic       wdata_protect;
  logic [2:0] wdata_swing;

  assign wdata_protect = wdata_i[7];
  assign wdata_swing   = wdata_i[2:0];

  ////////////////////////////////////////////////////////////////////////////
  property p_eq_write;
    wr_i && addr_i == ADDR_CH5_EQ |-> ##2 channel5_equalizer_level_o == $past(wdata_i, 2);
  endproperty
  property p_swing_write;
    wr_i && addr_i == ADDR_CH5_SWING |-> ##2
      (channel5_short_protect_en_o == $past(wdata_protect, 2) && channel5_output_swing_o == $past(wdata_swing, 2));
  endproperty
  property p_spare_trip;
    (wr_i && addr_i == ADDR_SPARE_B) ##2 (rd_i && addr_i == ADDR_SPARE_B) |=> rdata_o == $past(wdata_i, 3);
  endproperty

  a_reset_settings: assert property ($rose(rst_n_i) |-> channel5_equalizer_level_o == RST_EQ &&
    channel5_short_protect_en_o && channel5_output_swing_o == 3'h5 && !channel5_input_terminated_o)
    else $error("settings wrong after reset");
  a_eq_write_path: assert property (p_eq_write)
    else $error("equalizer output does not follow write");
  a_swing_write_path: assert property (p_swing_write)
    else $error("protect or swing output does not follow write");
  a_spare_read_back: assert property (p_spare_trip)
    else $error("spare register read back wrong");
  a_idle_read_zero: assert property (!rd_i |=> rdata_o == READ_ZERO)
    else $error("read data not zero outside read");
  a_eq_read_back: assert property (rd_i && addr_i == ADDR_CH5_EQ && !$past(wr_i) |=>
    rdata_o == $past(channel5_equalizer_level_o)) else $error("equalizer read differs from output");
  a_test_one_cycle: assert property (channel5_output_test_o |=> !channel5_output_test_o)
    else $error("detect test pulse longer than one cycle");
  a_test_while_hiz: assert property (channel5_output_test_o |-> !channel5_input_terminated_o)
    else $error("detect test while terminated");

  c_found: cover property ($rose(channel5_input_terminated_o));
  c_test: cover property (channel5_output_test_o);
  c_eq_write: cover property (wr_i && addr_i == ADDR_CH5_EQ);
endmodule // repeater_channel_config_regs_monitor

// >>> repeater_channel_config_regs_test.sv
// repeater_channel_config_regs_test: directed register and detect tests
// assumes the design package and monitor are compiled first
`timescale 1ns/1ps
module repeater_channel_config_regs_test;
  import repeater_cfg_pkg::*;
  localparam int PERIOD = 64;

  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic [1:0] apin = 2'h0;
  logic [1:0] dpin = 2'h0;
  logic [1:0] mpin = 2'h0;
  logic       found = 1'b0;
  logic [1:0] asel;
  logic [1:0] dsel;
  logic       term;
  logic       test;
  logic [7:0] eq;
  logic       prot;
  logic [2:0] swing;
  int         fails = 0;
  int         cmp_count = 0;
  int         test_cnt = 0;
  int         test_base = 0;
  int         cycles = 0;
  logic [7:0] rv;

  always #25 clk_i = ~clk_i;

  repeater_channel_config_regs #(.DETECT_PERIOD_CYCLES(PERIOD)) u_repeater_channel_config_regs (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .assert_thresh_pin_i(apin), .deassert_thresh_pin_i(dpin),
    .presence_mode_pin_i(mpin), .channel5_output_found_i(found), .assert_thresh_sel_o(asel),
    .deassert_thresh_sel_o(dsel), .channel5_input_terminated_o(term), .channel5_output_test_o(test),
    .channel5_equalizer_level_o(eq), .channel5_short_protect_en_o(prot), .channel5_output_swing_o(swing));

  ////////////////////////////////////////////////////////////////////////////
  // pulse count away from the rising edge
  always @(negedge clk_i) if (test === 1'b1) test_cnt++;

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("fails=%0d compares=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask

  task automatic pins(input logic [1:0] a, input logic [1:0] d, input logic [1:0] m, input logic f);
    @(posedge clk_i);
    apin <= a;
    dpin <= d;
    mpin <= m;
    found <= f;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(ADDR_CH4_THRESH); chk(rv, 8'h00);
    rd(ADDR_SPARE_A); chk(rv, 8'h00);
    rd(ADDR_SPARE_B); chk(rv, 8'h00);
    rd(ADDR_CH5_TERM); chk(rv, 8'h00);
    rd(ADDR_CH5_EQ); chk(rv, 8'h2F);
    rd(ADDR_CH5_SWING); chk(rv, 8'hAD);
    chk({4'h0, asel, dsel}, 8'h00);
    chk({prot, 4'h0, swing}, 8'h85);
    // settings write, read back and an unmapped place
    wr(ADDR_CH5_EQ, 8'h12);
    wr(ADDR_CH5_SWING, 8'h2E);
    wr(ADDR_SPARE_B, 8'hA5);
    wr(8'h40, 8'hFF);
    cyc(2);
    chk(eq, 8'h12);
    chk({prot, 4'h0, swing}, 8'h06);
    rd(ADDR_CH5_SWING); chk(rv, 8'h2E);
    rd(8'h40); chk(rv, 8'h00);
    wr(ADDR_SPARE_B, 8'h5A);
    rd(ADDR_SPARE_B); chk(rv, 8'h5A);
    wr(ADDR_CH5_SWING, 8'hAB);
    cyc(2);
    chk({prot, 4'h0, swing}, 8'h83);
    // thresholds: pins govern until the override is set
    wr(ADDR_CH4_THRESH, 8'h0B);
    for (int c = 0; c < 4; c++) begin
      pins(c[1:0], ~c[1:0], TERM_MODE_HIZ, 1'b0);
      cyc(8);
      chk({4'h0, asel, dsel}, {4'h0, c[1:0], ~c[1:0]});
    end
    wr(ADDR_OVERRIDE, 8'h40);
    rd(ADDR_OVERRIDE); chk(rv, 8'h40);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CH4_THRESH, {4'h0, c[1:0], 2'(3 - c)});
      cyc(2);
      chk({4'h0, asel, dsel}, {4'h0, c[1:0], 2'(3 - c)});
    end
    // termination from the pin, then from the register
    pins(2'h0, 2'h0, TERM_MODE_FIXED, 1'b0);
    cyc(8);
    chk({7'h0, term}, 8'h01);
    wr(ADDR_OVERRIDE, 8'h48);
    cyc(4);
    chk({7'h0, term}, 8'h00);
    wr(ADDR_CH5_TERM, 8'h0C);
    cyc(4);
    chk({7'h0, term}, 8'h01);
    rd(ADDR_CH5_TERM); chk(rv, 8'h8C);
    wr(ADDR_CH5_TERM, 8'h00);
    cyc(4);
    chk({7'h0, term}, 8'h00);
    // endless detect mode, receiver appears late
    test_base = test_cnt;
    wr(ADDR_CH5_TERM, 8'h08);
    cyc(PERIOD * 5 - 32);
    chk(8'(test_cnt - test_base), 8'h05);
    chk({7'h0, term}, 8'h00);
    pins(2'h0, 2'h0, TERM_MODE_FIXED, 1'b1);
    cyc(PERIOD + 16);
    chk({7'h0, term}, 8'h01);
    rd(ADDR_CH5_TERM); chk(rv, 8'h88);
    // limited detect mode gives up after the attempt limit
    pins(2'h0, 2'h0, TERM_MODE_FIXED, 1'b0);
    cyc(8);
    test_base = test_cnt;
    wr(ADDR_CH5_TERM, 8'h04);
    cyc(PERIOD * 52);
    chk(8'(test_cnt - test_base), 8'h32);
    chk({7'h0, term}, 8'h00);
    rd(ADDR_CH5_STATUS); chk(rv, {2'(TS_GAVE_UP), DETECT_ATTEMPT_LIMIT});
    pins(2'h0, 2'h0, TERM_MODE_FIXED, 1'b1);
    cyc(PERIOD * 2);
    chk({7'h0, term}, 8'h00);
    chk(8'(test_cnt - test_base), 8'h32);
    print_verdict();
  end
endmodule // repeater_channel_config_regs_test

bind repeater_channel_config_regs repeater_channel_config_regs_monitor u_repeater_channel_config_regs_monitor (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .channel5_input_terminated_o(channel5_input_terminated_o),
  .channel5_output_test_o(channel5_output_test_o), .channel5_equalizer_level_o(channel5_equalizer_level_o),
  .channel5_short_protect_en_o(channel5_short_protect_en_o), .channel5_output_swing_o(channel5_output_swing_o));
